// >>> inc/op_exec_pkg.sv
// Purpose: Shared constants and carriers for the four-instruction execution block
// Assumes: 8-bit data, 16-bit program and stack addresses
// Notes: Register map sits on AHB-Lite, one word per register
package op_exec_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_OPER = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_PC = 8'h0C;
  localparam logic [7:0] OFS_SP = 8'h10;
  localparam logic [7:0] OFS_RESULT = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_MEM_BASE = 8'h80;
  // Command codes written to OFS_CMD
  localparam logic [1:0] CMD_PUSH_UP = 2'h0;
  localparam logic [1:0] CMD_CLR_CARRY = 2'h1;
  localparam logic [1:0] CMD_RETURN = 2'h2;
  localparam logic [1:0] CMD_ROTATE = 2'h3;
  // Flag bit positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_S = 2;
  localparam int FLG_V = 3;
  localparam int FLG_D = 4;
  localparam int FLG_H = 5;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [15:0] SP_POP_STEP = 16'h0002;

  typedef struct packed {
    logic [7:0] ptr_reg;
    logic [7:0] src_reg;
    logic [7:0] operand;
  } oper_t;

  typedef struct packed {
    logic flag_c;
    logic flag_z;
    logic flag_s;
    logic flag_v;
  } rot_flags_t;
endpackage : op_exec_pkg

// >>> logic/rotate_left_unit.sv
// Purpose: Rotate-left datapath with flag results
// Assumes: Purely combinational, 8-bit operand
// Notes: Overflow means the sign bit changed
`timescale 1ns/1ns
module rotate_left_unit
  import op_exec_pkg::*;
(
  input wire logic [7:0] i_operand,
  output logic [7:0] o_result,
  output rot_flags_t o_flags
);
  always_comb begin
    o_result = {i_operand[6:0], i_operand[7]};
    o_flags.flag_c = i_operand[7];
    o_flags.flag_z = (o_result == 8'h00);
    o_flags.flag_s = o_result[7];
    o_flags.flag_v = o_result[7] ^ i_operand[7];
  end
endmodule : rotate_left_unit

// >>> logic/op_exec.sv
// Purpose: Executes user-stack push, clear-carry, return and rotate-left
// Assumes: AHB-Lite single word transfers; internal register file and stack memory
// Notes: Register file and data memory share one byte array reached by address
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ns

module op_exec
  import op_exec_pkg::*;
#(
  parameter int MEM_AW = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [15:0] o_fetch_addr,
  output logic o_busy
);
  localparam int MEM_DEPTH = 1 << MEM_AW;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PUSH_PTR = 5'b00010,
    ST_PUSH_WR = 5'b00100,
    ST_RET_HI = 5'b01000,
    ST_RET_LO = 5'b10000
  } state_t;

  typedef struct packed {
    state_t state;
    logic [1:0] cmd;
    oper_t oper;
    logic [5:0] flags;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0] result;
    logic [7:0] ptr_new;
    logic ph_wr;
    logic ph_rd;
    logic [11:0] ph_addr;
    logic [31:0] rdata;
    logic [15:0] fetch;
    logic busy;
  } core_t;

  core_t s_r;
  core_t s_nxt;
  logic [7:0] mem_r [MEM_DEPTH];
  logic mem_we;
  logic [MEM_AW-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic [7:0] rot_res;
  rot_flags_t rot_flg;

  function automatic logic [MEM_AW-1:0] maddr(input logic [15:0] a);
    maddr = a[MEM_AW-1:0];
  endfunction : maddr

  localparam logic [11:0] WIN_BASE = 12'(OFS_MEM_BASE);
  localparam logic [11:0] WIN_END = WIN_BASE + 12'(MEM_DEPTH * 2);

  // True for an aligned word inside the byte window
  function automatic logic mem_hit(input logic [11:0] a);
    mem_hit = (a >= WIN_BASE) && (a < WIN_END) && (a[1:0] == 2'b00);
  endfunction : mem_hit

  // Window word k lands on entry k of the upper half; lower half is core-only
  function automatic logic [MEM_AW-1:0] win_idx(input logic [11:0] a);
    logic [11:0] ofs;
    ofs = a - WIN_BASE;
    win_idx = {1'b1, ofs[MEM_AW:2]};
  endfunction : win_idx

  // Register offsets sit in the low byte of the 4 KiB decode
  function automatic logic is_reg(input logic [11:0] a, input logic [7:0] ofs);
    is_reg = (a == {4'h0, ofs});
  endfunction : is_reg

  // Pointer wraps inside the byte-wide register file
  function automatic logic [7:0] bump(input logic [7:0] v);
    bump = v + 8'h01;
  endfunction : bump

  // Both popped bytes are skipped at once
  function automatic logic [15:0] pop_sp(input logic [15:0] v);
    pop_sp = v + SP_POP_STEP;
  endfunction : pop_sp

  // Only carry moves; the other five flags ride through
  function automatic logic [5:0] clear_carry(input logic [5:0] old);
    clear_carry = old;
    clear_carry[FLG_C] = 1'b0;
  endfunction : clear_carry

  // Rotate rewrites four flags; decimal-adjust and half-carry ride through
  function automatic logic [5:0] rot_flags(input logic [5:0] old, input rot_flags_t r);
    rot_flags = old;
    rot_flags[FLG_C] = r.flag_c;
    rot_flags[FLG_Z] = r.flag_z;
    rot_flags[FLG_S] = r.flag_s;
    rot_flags[FLG_V] = r.flag_v;
  endfunction : rot_flags

  // Commands that need memory cycles leave idle
  function automatic state_t cmd_state(input logic [1:0] code);
    case (code)
      CMD_PUSH_UP: begin
        cmd_state = ST_PUSH_PTR;
      end
      CMD_RETURN: begin
        cmd_state = ST_RET_HI;
      end
      default: begin
        cmd_state = ST_IDLE;
      end
    endcase
  endfunction : cmd_state

  // Register read mux; window bytes are merged by the caller
  function automatic logic [31:0] reg_read(input core_t c, input logic [11:0] a);
    reg_read = 32'h0000_0000;
    case (a)
      {4'h0, OFS_CMD}: begin
        reg_read = {30'h0, c.cmd};
      end
      {4'h0, OFS_OPER}: begin
        reg_read = {8'h00, c.oper};
      end
      {4'h0, OFS_FLAGS}: begin
        reg_read = {26'h0, c.flags};
      end
      {4'h0, OFS_PC}: begin
        reg_read = {16'h0, c.pc};
      end
      {4'h0, OFS_SP}: begin
        reg_read = {16'h0, c.sp};
      end
      {4'h0, OFS_RESULT}: begin
        reg_read = {24'h0, c.result};
      end
      {4'h0, OFS_STATUS}: begin
        reg_read = {31'h0, c.busy};
      end
      default: begin
        reg_read = 32'h0000_0000;
      end
    endcase
  endfunction : reg_read

  // Reset image of the whole state
  localparam core_t CORE_RST = '{
    state: ST_IDLE,
    cmd: CMD_PUSH_UP,
    oper: '0,
    flags: FLAGS_RST,
    pc: PC_RST,
    sp: SP_RST,
    result: 8'h00,
    ptr_new: 8'h00,
    ph_wr: 1'b0,
    ph_rd: 1'b0,
    ph_addr: 12'h000,
    rdata: 32'h0000_0000,
    fetch: PC_RST,
    busy: 1'b0
  };

  rotate_left_unit u_rot (
    .i_operand(s_r.oper.operand),
    .o_result(rot_res),
    .o_flags(rot_flg)
  );

  always_comb begin
    logic [15:0] pc_tmp;
    logic [31:0] rd;
    logic [11:0] ma;
    logic take;
    logic cmd_wr;
    logic [MEM_AW-1:0] ptr_idx;
    logic [MEM_AW-1:0] src_idx;
    logic [MEM_AW-1:0] sp_idx;
    pc_tmp = s_r.pc;
    rd = 32'h0000_0000;
    ma = 12'h000;
    take = 1'b0;
    cmd_wr = 1'b0;
    ptr_idx = maddr({8'h00, s_r.oper.ptr_reg});
    src_idx = maddr({8'h00, s_r.oper.src_reg});
    sp_idx = maddr(s_r.sp);
    s_nxt = s_r;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = 8'h00;
    // Writes above the 4 KiB decode are dropped so they cannot alias
    take = i_hsel && i_hready && i_htrans[1];
    s_nxt.ph_wr = take && i_hwrite && (i_haddr[31:12] == 20'h0_0000);
    s_nxt.ph_rd = take && !i_hwrite;
    if (take) begin
      s_nxt.ph_addr = i_haddr[11:0];
    end
    // Read data latched at the address edge stands through the data phase
    if (s_nxt.ph_rd) begin
      ma = i_haddr[11:0];
      if (i_haddr[31:12] != 20'h0_0000) begin
        rd = 32'h0000_0000;
      end else if (mem_hit(ma)) begin
        rd = {24'h00_0000, mem_r[win_idx(ma)]};
      end else begin
        rd = reg_read(s_r, ma);
      end
      s_nxt.rdata = rd;
    end
    cmd_wr = s_r.ph_wr && is_reg(s_r.ph_addr, OFS_CMD);
    // Execution engine; register writes are only taken while idle
    case (s_r.state)
      ST_IDLE: begin
        if (cmd_wr) begin
          s_nxt.cmd = i_hwdata[1:0];
          s_nxt.state = cmd_state(i_hwdata[1:0]);
          s_nxt.busy = (s_nxt.state != ST_IDLE);
          case (i_hwdata[1:0])
            CMD_CLR_CARRY: begin
              s_nxt.flags = clear_carry(s_r.flags);
              s_nxt.busy = 1'b0;
            end
            CMD_ROTATE: begin
              s_nxt.result = rot_res;
              s_nxt.flags = rot_flags(s_r.flags, rot_flg);
              s_nxt.oper.operand = rot_res;
              s_nxt.busy = 1'b0;
            end
            default: begin
              s_nxt.result = s_r.result;
            end
          endcase
        end else if (s_r.ph_wr) begin
          case (s_r.ph_addr)
            {4'h0, OFS_OPER}: begin
              s_nxt.oper = i_hwdata[23:0];
            end
            {4'h0, OFS_FLAGS}: begin
              s_nxt.flags = i_hwdata[5:0];
            end
            {4'h0, OFS_PC}: begin
              s_nxt.pc = i_hwdata[15:0];
            end
            {4'h0, OFS_SP}: begin
              s_nxt.sp = i_hwdata[15:0];
            end
            default: begin
              if (mem_hit(s_r.ph_addr)) begin
                mem_we = 1'b1;
                mem_wa = win_idx(s_r.ph_addr);
                mem_wd = i_hwdata[7:0];
              end
            end
          endcase
        end
      end
      ST_PUSH_PTR: begin
        // Pointer lives in the register file (byte array)
        s_nxt.ptr_new = bump(mem_r[ptr_idx]);
        mem_we = 1'b1;
        mem_wa = ptr_idx;
        mem_wd = s_nxt.ptr_new;
        s_nxt.state = ST_PUSH_WR;
      end
      ST_PUSH_WR: begin
        // Source read after pointer update; source itself untouched
        mem_we = 1'b1;
        mem_wa = maddr({8'h00, s_r.ptr_new});
        mem_wd = mem_r[src_idx];
        s_nxt.busy = 1'b0;
        s_nxt.state = ST_IDLE;
      end
      ST_RET_HI: begin
        // High byte first, from the byte the stack pointer names
        pc_tmp[15:8] = mem_r[sp_idx];
        s_nxt.pc = pc_tmp;
        s_nxt.state = ST_RET_LO;
      end
      ST_RET_LO: begin
        // Low byte follows, then the pointer moves past both
        pc_tmp[7:0] = mem_r[maddr(s_r.sp + 16'h0001)];
        s_nxt.pc = pc_tmp;
        s_nxt.sp = pop_sp(s_r.sp);
        s_nxt.fetch = pc_tmp;
        s_nxt.busy = 1'b0;
        s_nxt.state = ST_IDLE;
      end
      default: begin
        s_nxt.state = ST_IDLE;
      end
    endcase
    // Fetch follows the program counter while idle, held back at a return start
    if (s_r.state == ST_IDLE && !(cmd_wr && i_hwdata[1:0] == CMD_RETURN)) begin
      s_nxt.fetch = s_nxt.pc;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= CORE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Memory has no reset; software preloads it
  always_ff @(posedge i_clk) begin
    if (mem_we) begin
      mem_r[mem_wa] <= mem_wd;
    end
  end

  // Zero-wait slave with an always OKAY response
  assign o_hrdata = s_r.rdata;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_fetch_addr = s_r.fetch;
  assign o_busy = s_r.busy;
endmodule : op_exec

// >>> sim/op_exec_properties.sv
// Purpose: Port-level timing checks of the execution block
// Assumes: Zero-wait slave; command taken in the data phase
// Notes: Flag and memory contents are judged by the bench
`timescale 1ns/1ns
module op_exec_properties
  import op_exec_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [15:0] o_fetch_addr,
  input wire logic o_busy
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic cmd_q, jump_q, go;
  logic [1:0] code;
  assign go = cmd_q && i_hready && !o_busy;
  assign code = i_hwdata[1:0];
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_q <= 1'b0;
      jump_q <= 1'b0;
    end else if (i_hready) begin
      cmd_q <= i_hsel && i_htrans[1] && i_hwrite && i_haddr == 32'(OFS_CMD);
      jump_q <= i_hsel && i_htrans[1] && i_hwrite && i_haddr == 32'(OFS_PC);
    end
  end
  property p_push_busy; go && code == CMD_PUSH_UP |=> o_busy [*2] ##1 !o_busy; endproperty
  a_push_busy: assert property (p_push_busy) else $error("push busy span wrong");
  property p_push_end; go && code == CMD_PUSH_UP |-> ##3 $fell(o_busy); endproperty
  a_push_end: assert property (p_push_end) else $error("push end late");
  property p_clr_quick; go && code == CMD_CLR_CARRY |=> !o_busy [*3]; endproperty
  a_clr_quick: assert property (p_clr_quick) else $error("clear went busy");
  property p_back_busy; go && code == CMD_RETURN |=> o_busy [*2] ##1 !o_busy; endproperty
  a_back_busy: assert property (p_back_busy) else $error("return busy span wrong");
  property p_back_end; go && code == CMD_RETURN |-> ##3 $fell(o_busy); endproperty
  a_back_end: assert property (p_back_end) else $error("return end late");
  property p_rot_quick; go && code == CMD_ROTATE |=> !o_busy [*2]; endproperty
  a_rot_quick: assert property (p_rot_quick) else $error("rotate went busy");
  property p_fetch_hold; !o_busy && !jump_q |=> $stable(o_fetch_addr); endproperty
  a_fetch_hold: assert property (p_fetch_hold) else $error("fetch moved");
  property p_jump; jump_q && !o_busy |=> o_fetch_addr == $past(i_hwdata[15:0]); endproperty
  a_jump: assert property (p_jump) else $error("fetch not loaded");
  c_push: cover property (go && code == CMD_PUSH_UP);
  c_back: cover property (go && code == CMD_RETURN);
  c_rot: cover property (go && code == CMD_ROTATE);
endmodule : op_exec_properties
bind op_exec op_exec_properties u_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
  .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata),
  .i_hready(i_hready), .o_fetch_addr(o_fetch_addr), .o_busy(o_busy));

// >>> sim/fetch_partner.sv
// Purpose: Fetch-side stand-in latching the address fetched after a long op
// Assumes: Fetch resumes in the cycle busy drops
// Notes: Behavioural only
`timescale 1ns/1ns
module fetch_partner (
  input wire logic i_clk,
  input wire logic [15:0] i_fetch_addr,
  input wire logic i_busy,
  output logic [15:0] o_last_fetch
);
  logic busy_r = 1'b0;
  initial o_last_fetch = 16'h0000;
  always @(posedge i_clk) begin
    busy_r <= i_busy;
    if (busy_r && !i_busy) begin
      o_last_fetch <= i_fetch_addr;
    end
  end
endmodule : fetch_partner

// >>> sim/op_exec_tb.sv
// Purpose: Self-checking bench of the execution block
// Assumes: Zero-wait slave; byte data in the low bits
// Notes: Reads queue their expectation; a monitor compares at the data edge
`timescale 1ns/1ns
module op_exec_tb;
  import op_exec_pkg::*;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0, rd_dp = 1'b0;
  logic [31:0] i_haddr = 32'h0000_0000, i_hwdata = 32'h0000_0000, rnd = 32'h0000_f0bf;
  logic [1:0] i_htrans = 2'h0;
  logic [31:0] o_hrdata, r;
  logic o_hreadyout, o_hresp, o_busy;
  logic [15:0] o_fetch_addr, last_fetch;
  logic [31:0] exp_q[$];
  logic [7:0] p, s, x, y, f;
  logic [7:0] tbl [5] = '{8'h00, 8'h80, 8'h40, 8'hc1, 8'h7f};
  int fails = 0, comparisons = 0, cyc = 0;
  always #25 i_clk = ~i_clk;
  op_exec DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_fetch_addr(o_fetch_addr), .o_busy(o_busy));
  fetch_partner u_fetch (.i_clk(i_clk), .i_fetch_addr(o_fetch_addr), .i_busy(o_busy),
    .o_last_fetch(last_fetch));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function automatic logic [31:0] madr(input logic [7:0] k);
    return 32'h0000_0080 + 32'({k - 8'h80, 2'b00});
  endfunction : madr
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic report_and_stop;
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input logic c);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= a;
    i_hwrite <= w;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    rd_dp <= c;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    r = o_hrdata;
    rd_dp <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 1'b0);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0000_0000, 1'b1);
  endtask : rd
  task automatic idle;
    for (int i = 0; i < 20; i++) begin
      xfer(1'b0, 32'(OFS_STATUS), 32'h0000_0000, 1'b0);
      if (r[0] === 1'b0) break;
    end
  endtask : idle
  always @(posedge i_clk) begin
    cyc++;
    if (rd_dp && o_hreadyout) check(o_hrdata, exp_q.pop_front());
    if (cyc == 3000) begin
      fails++;
      report_and_stop;
    end
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    rnd = lfsr(rnd);
    p = 8'ha0 + {3'h0, rnd[4:0]};
    s = rnd[15:8];
    wr(madr(8'h90), 32'(p));
    wr(madr(8'h91), 32'(s));
    wr(32'(OFS_OPER), 32'h0090_9100);
    wr(32'(OFS_CMD), 32'(CMD_PUSH_UP));
    idle;
    rd(madr(8'h90), 32'(p + 8'h01));
    rd(madr(p + 8'h01), 32'(s));
    rd(madr(8'h91), 32'(s));
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      f = (i == 0) ? 8'h3f : {2'h0, rnd[5:0]};
      wr(32'(OFS_FLAGS), 32'(f));
      wr(32'(OFS_CMD), 32'(CMD_CLR_CARRY));
      rd(32'(OFS_FLAGS), 32'(f & 8'h3e));
    end
    rnd = lfsr(rnd);
    wr(32'(OFS_PC), {16'h0000, rnd[31:16]});
    wr(32'(OFS_SP), 32'h0000_00f0);
    wr(madr(8'hf0), 32'(rnd[15:8]));
    wr(madr(8'hf1), 32'(rnd[7:0]));
    wr(32'(OFS_FLAGS), 32'h0000_003f);
    wr(32'(OFS_CMD), 32'(CMD_RETURN));
    // Lands while busy, so it must be dropped
    wr(32'(OFS_CMD), 32'(CMD_CLR_CARRY));
    idle;
    rd(32'(OFS_PC), {16'h0000, rnd[15:0]});
    rd(32'(OFS_SP), 32'h0000_00f2);
    rd(32'(OFS_FLAGS), 32'h0000_003f);
    check({16'h0000, last_fetch}, {16'h0000, rnd[15:0]});
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      x = (i < 5) ? tbl[i] : rnd[7:0];
      y = {x[6:0], x[7]};
      f = {2'h0, rnd[13:8]};
      wr(32'(OFS_FLAGS), 32'(f));
      wr(32'(OFS_OPER), 32'(x));
      wr(32'(OFS_CMD), 32'(CMD_ROTATE));
      rd(32'(OFS_RESULT), 32'(y));
      rd(32'(OFS_FLAGS), 32'({f[5:4], y[7] ^ x[7], y[7], y == 8'h00, x[7]}));
    end
    rd(32'h0000_001c, 32'h0000_0000);
    report_and_stop;
  end
endmodule : op_exec_tb
